//--- rtl/isem_interrupt_enable.sv
// interrupt source enable mask with apb register access
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "isem_map.svh"

module isem_interrupt_enable
(
    // apb
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    input  wire logic [3:0]         pstrb,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // source flags
    input  wire logic               converter_done_flag,
    input  wire logic               brownout_below,
    input  wire logic               uart_tx_done_flag,
    input  wire logic               uart_rx_done_flag,
    input  wire logic               timer1_overflow_flag,
    input  wire logic               ext_line1,
    input  wire logic               timer0_overflow_flag,
    input  wire logic               ext_line0,
    // to the core
    output isem_pkg::isem_req_t     core_req,
    output logic                    brownout_event_flag,
    output logic                    irq
);
    import isem_pkg::*;

    isem_byte_t interrupt_source_enable;
    isem_byte_t irq_status;
    isem_byte_t irq_mask;
    isem_req_t  next_req;
    isem_req_t  req_q;
    logic       below_q;
    logic       below_seen;
    logic       wr;
    logic       rd_ok;
    logic       brownout_crossing;
    isem_req_t  status_bits;
    logic       wr_enable;
    logic       wr_bitset;
    logic       wr_bitclr;
    logic       wr_flags;
    logic       wr_status;
    logic       wr_mask;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a[11:2] == off[11:2]);
    endfunction

    function automatic logic mapped(input logic [11:0] a);
        mapped = hit(a, `ISEM_ENABLE_OFF) || hit(a, `ISEM_BITSET_OFF)
              || hit(a, `ISEM_BITCLR_OFF) || hit(a, `ISEM_FLAGS_OFF)
              || hit(a, `ISEM_REQ_OFF) || hit(a, `ISEM_IRQ_STATUS_OFF)
              || hit(a, `ISEM_IRQ_MASK_OFF);
    endfunction

    // zero wait states: access phase always completes
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped(paddr);
    assign wr      = psel && penable && pwrite && mapped(paddr) && pstrb[0];
    assign rd_ok   = psel && !penable && !pwrite;

    // per-register write strobes, decoded once and shared by every register process
    assign wr_enable = wr && hit(paddr, `ISEM_ENABLE_OFF);
    assign wr_bitset = wr && hit(paddr, `ISEM_BITSET_OFF);
    assign wr_bitclr = wr && hit(paddr, `ISEM_BITCLR_OFF);
    assign wr_flags  = wr && hit(paddr, `ISEM_FLAGS_OFF);
    assign wr_status = wr && hit(paddr, `ISEM_IRQ_STATUS_OFF);
    assign wr_mask   = wr && hit(paddr, `ISEM_IRQ_MASK_OFF);

    // byte write plus write-one-to-set and write-one-to-clear byte ports
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            interrupt_source_enable <= `ISEM_ENABLE_RESET;
        else if (wr_enable)
            interrupt_source_enable <= pwdata[7:0];
        else if (wr_bitset)
            interrupt_source_enable <= interrupt_source_enable | pwdata[7:0];
        else if (wr_bitclr)
            interrupt_source_enable <= interrupt_source_enable & ~pwdata[7:0];
    end

    // the first sample after reset sees no crossing, since below_seen is still clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            below_q    <= 1'b0;
            below_seen <= 1'b0;
        end
        else
        begin
            below_q    <= brownout_below;
            below_seen <= 1'b1;
        end
    end

    assign brownout_crossing = below_seen && (below_q != brownout_below);

    // set beats a simultaneous software clear so no crossing is lost
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            brownout_event_flag <= 1'b0;
        else if (brownout_crossing)
            brownout_event_flag <= 1'b1;
        else if (wr_flags && pwdata[`ISEM_BROWNOUT_BIT])
            brownout_event_flag <= 1'b0;
    end

    always_comb
    begin
        next_req = '0;
        if (interrupt_source_enable[`ISEM_GLOBAL_BIT])
        begin
            next_req[6] = converter_done_flag
                && interrupt_source_enable[`ISEM_CONVERTER_BIT];
            next_req[5] = brownout_event_flag
                && interrupt_source_enable[`ISEM_BROWNOUT_BIT];
            next_req[4] = (uart_tx_done_flag || uart_rx_done_flag)
                && interrupt_source_enable[`ISEM_UART_BIT];
            next_req[3] = timer1_overflow_flag
                && interrupt_source_enable[`ISEM_TIMER1_BIT];
            next_req[2] = ext_line1
                && interrupt_source_enable[`ISEM_EXT1_BIT];
            next_req[1] = timer0_overflow_flag
                && interrupt_source_enable[`ISEM_TIMER0_BIT];
            next_req[0] = ext_line0
                && interrupt_source_enable[`ISEM_EXT0_BIT];
        end
    end

    // the core sees the gated requests in the same cycle
    assign core_req = next_req;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            req_q <= '0;
        else
            req_q <= next_req;
    end

    // sticky status: rising request edge sets, write-one clears, set wins
    // one flop per source, so a clear of one bit never races another source's set
    genvar g;
    generate
        for (g = 0; g < 7; g++)
        begin : g_status
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    status_bits[g] <= 1'b0;
                else if (next_req[g] && !req_q[g])
                    status_bits[g] <= 1'b1;
                else if (wr_status && pwdata[g])
                    status_bits[g] <= 1'b0;
            end
        end
    endgenerate

    // bit 7 has no source behind it and always reads zero
    assign irq_status = {1'b0, status_bits};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_mask <= `ISEM_MASK_RESET;
        else if (wr_mask)
            irq_mask <= {1'b0, pwdata[6:0]};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(irq_status & irq_mask);
    end

    // read data registered in the setup phase, valid in the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (rd_ok)
        begin
            if (hit(paddr, `ISEM_ENABLE_OFF))
                prdata <= {24'h00_0000, interrupt_source_enable};
            else if (hit(paddr, `ISEM_FLAGS_OFF))
                prdata <= {26'h000_0000, brownout_event_flag, 5'h00};
            else if (hit(paddr, `ISEM_REQ_OFF))
                prdata <= {25'h000_0000, next_req};
            else if (hit(paddr, `ISEM_IRQ_STATUS_OFF))
                prdata <= {24'h00_0000, irq_status};
            else if (hit(paddr, `ISEM_IRQ_MASK_OFF))
                prdata <= {24'h00_0000, irq_mask};
            else
                prdata <= 32'h0000_0000;
        end
    end
endmodule
`default_nettype wire

//--- rtl/isem_map.svh
// register offsets, field positions and reset values of the interrupt enable block
`ifndef ISEM_MAP_SVH
`define ISEM_MAP_SVH

`define ISEM_ENABLE_OFF       12'h0a8
`define ISEM_BITSET_OFF       12'h100
`define ISEM_BITCLR_OFF       12'h104
`define ISEM_FLAGS_OFF        12'h108
`define ISEM_REQ_OFF          12'h10c
`define ISEM_IRQ_STATUS_OFF   12'h110
`define ISEM_IRQ_MASK_OFF     12'h114

`define ISEM_GLOBAL_BIT       7
`define ISEM_CONVERTER_BIT    6
`define ISEM_BROWNOUT_BIT     5
`define ISEM_UART_BIT         4
`define ISEM_TIMER1_BIT       3
`define ISEM_EXT1_BIT         2
`define ISEM_TIMER0_BIT       1
`define ISEM_EXT0_BIT         0

`define ISEM_ENABLE_RESET     8'h00
`define ISEM_MASK_RESET       8'h00

`endif

//--- rtl/isem_pkg.sv
// types shared by the interrupt enable block
package isem_pkg;
    typedef logic [7:0] isem_byte_t;
    typedef logic [6:0] isem_req_t;
endpackage

//--- bench/isem_core_model.sv
// processor core stand-in: counts interrupt entries
`timescale 1ns/1ps
`default_nettype none
module isem_core_model
(
    input  wire logic pclk, presetn, irq,
    output int        n_irq
);
    logic last;
    // one entry per rising edge, a held level is one service
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            n_irq <= 0;
            last  <= 1'b0;
        end
        else
        begin
            last <= irq;
            if (irq && !last) n_irq <= n_irq + 1;
        end
endmodule
`default_nettype wire

//--- bench/isem_properties.sv
// assertions for the interrupt enable block
`timescale 1ns/1ps
`default_nettype none
module isem_properties
(
    input wire logic pclk, presetn, psel, penable, pwrite, irq, brownout_event_flag,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic [3:0] pstrb,
    input wire logic converter_done_flag, brownout_below, uart_tx_done_flag,
    input wire logic uart_rx_done_flag, timer1_overflow_flag, ext_line1,
    input wire logic timer0_overflow_flag, ext_line0,
    input wire isem_pkg::isem_req_t core_req
);
    import isem_pkg::*;
    logic [7:0] en;
    logic [6:0] w;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // shadow of the enable byte, fed only by accepted writes
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) en <= 8'h00;
        else if (psel && penable && pwrite && pstrb[0])
            en <= paddr == 12'h0a8 ? pwdata[7:0] : paddr == 12'h100 ? en | pwdata[7:0]
                : paddr == 12'h104 ? en & ~pwdata[7:0] : en;
    assign w = {7{en[7]}} & en[6:0] & {converter_done_flag, brownout_event_flag,
        uart_tx_done_flag | uart_rx_done_flag, timer1_overflow_flag, ext_line1,
        timer0_overflow_flag, ext_line0};
    property p_off; !en[7] |-> core_req == 7'h00; endproperty
    a_off: assert property (p_off) else $error("request while off");
    property p_cv; core_req[6] == w[6]; endproperty
    a_cv: assert property (p_cv) else $error("converter request");
    property p_bo; core_req[5] == w[5]; endproperty
    a_bo: assert property (p_bo) else $error("brownout request");
    property p_ua; core_req[4] == w[4]; endproperty
    a_ua: assert property (p_ua) else $error("serial request");
    property p_t1; core_req[3] == w[3]; endproperty
    a_t1: assert property (p_t1) else $error("timer1 request");
    property p_x1; core_req[2] == w[2]; endproperty
    a_x1: assert property (p_x1) else $error("line1 request");
    property p_t0; core_req[1] == w[1]; endproperty
    a_t0: assert property (p_t0) else $error("timer0 request");
    property p_x0; core_req[0] == w[0]; endproperty
    a_x0: assert property (p_x0) else $error("line0 request");
    property p_rd; psel && penable && !pwrite && paddr == 12'h0a8 |-> prdata == {24'h0, en};
    endproperty
    a_rd: assert property (p_rd) else $error("enable readback");
    property p_bf; $changed(brownout_below) |=> brownout_event_flag; endproperty
    a_bf: assert property (p_bf) else $error("brownout flag");
    c_all: cover property (core_req == 7'h7f);
    c_bf: cover property ($rose(brownout_event_flag));
    c_irq: cover property ($rose(irq));
endmodule
bind isem_interrupt_enable isem_properties u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .irq(irq), .paddr(paddr),
    .brownout_event_flag(brownout_event_flag), .pwdata(pwdata), .prdata(prdata),
    .pstrb(pstrb), .converter_done_flag(converter_done_flag), .ext_line0(ext_line0),
    .brownout_below(brownout_below), .uart_tx_done_flag(uart_tx_done_flag),
    .uart_rx_done_flag(uart_rx_done_flag), .timer1_overflow_flag(timer1_overflow_flag),
    .ext_line1(ext_line1), .timer0_overflow_flag(timer0_overflow_flag),
    .core_req(core_req));
`default_nettype wire

//--- bench/test_interrupt_source_enable_mask.sv
// self-checking bench of the interrupt enable block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin n_errors++; \
    $display("ERROR %s expected %h seen %h", n, e, s); end end
module test_interrupt_source_enable_mask;
    import isem_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, bo_flag;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h4c3c3ac0;
    logic [6:0] fl = 7'h00;
    logic brb = 0, err;
    isem_req_t req;
    int n_errors = 0, compares = 0, cyc = 0, n_irq;
    isem_interrupt_enable uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .converter_done_flag(fl[6]), .brownout_below(brb),
        .uart_tx_done_flag(fl[5]), .uart_rx_done_flag(fl[4]), .timer1_overflow_flag(fl[3]),
        .ext_line1(fl[2]), .timer0_overflow_flag(fl[1]), .ext_line0(fl[0]),
        .core_req(req), .brownout_event_flag(bo_flag), .irq(irq));
    isem_core_model core (.pclk(pclk), .presetn(presetn), .irq(irq), .n_irq(n_irq));
    always #12.5 pclk = ~pclk;
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // brownout bit stays clear in the random part, so request bit 5 is taken as zero
    function automatic logic [6:0] want(logic [7:0] en, logic [6:0] f);
        return en[7] ? en[6:0] & {f[6], 1'b0, f[5] | f[4], f[3:0]} : 7'h00;
    endfunction
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_errors++;
            print_verdict;
        end
    end
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        apb(0, 12'h0a8, 0);
        `CHK("enable reset", 32'h0, rd)
        for (int i = 0; i < 24; i++)
        begin
            seed = lfsr(seed);
            if (i < 2) seed[14:0] = i ? 15'h7fff : 15'h7f7f;
            apb(1, 12'h0a8, seed[7:0]);
            fl <= seed[14:8];
            apb(0, 12'h10c, 0);
            `CHK("core_req", want(seed[7:0], seed[14:8]), req)
            `CHK("req reg", {25'h0, want(seed[7:0], seed[14:8])}, rd)
        end
        $display("random gating done");
        apb(1, 12'h0a8, 8'h01);
        apb(1, 12'h100, 8'h82);
        apb(1, 12'h104, 8'h01);
        apb(0, 12'h0a8, 0);
        `CHK("bit set clear", 32'h82, rd)
        apb(0, 12'h3fc, 0);
        `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped data", 32'h0, rd)
        $display("register access done");
        fl <= 7'h00;
        apb(1, 12'h0a8, 8'hff);
        apb(1, 12'h110, 8'h7f);
        apb(1, 12'h114, 8'h7f);
        fl <= 7'h01;
        repeat (4) @(posedge pclk);
        `CHK("irq raised", 1'b1, irq)
        `CHK("core entries", 1, n_irq)
        apb(1, 12'h114, 8'h00);
        repeat (2) @(posedge pclk);
        `CHK("irq masked", 1'b0, irq)
        apb(1, 12'h110, 8'h01);
        apb(1, 12'h114, 8'h7f);
        @(posedge pclk);
        `CHK("irq cleared", 1'b0, irq)
        $display("interrupt done");
        brb <= 1;
        repeat (2) @(posedge pclk);
        `CHK("brownout flag", 1'b1, bo_flag)
        `CHK("brownout req", 1'b1, req[5])
        apb(1, 12'h108, 8'h20);
        @(posedge pclk);
        `CHK("brownout clear", 1'b0, bo_flag)
        $display("brownout done");
        print_verdict;
    end
endmodule
`default_nettype wire
